// ==== core/step_diag_pkg.sv ====
// Package for the micro-step translator and diagnostics block.
// Assumes a single 10 MHz clock; register map reached over AXI4-Lite.
package step_diag_pkg;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFFS   = 8'h00;
   localparam logic [7:0] STAT0_OFFS  = 8'h04;
   localparam logic [7:0] STAT1_OFFS  = 8'h08;
   localparam logic [7:0] STAT2_OFFS  = 8'h0c;
   localparam logic [7:0] POS_OFFS    = 8'h10;
   localparam logic [7:0] CLEAR_OFFS  = 8'h14;

   // Control field positions
   localparam int RES_LSB    = 0;   // stepping_resolution_field [2:0]
   localparam int CODE_LSB   = 4;   // coil_amplitude_code [8:4]
   localparam int DIR_BIT    = 12;  // rotation_sense_bit
   localparam int POL_BIT    = 13;  // step_edge_polarity
   localparam int TRANSP_BIT = 14;  // backemf_transparency_bit
   localparam int DIV_BIT    = 15;  // backemf_divider_bit

   // Status 0 bit positions
   localparam int TW_BIT   = 0;
   localparam int OPA_BIT  = 1;
   localparam int OPB_BIT  = 2;
   localparam int CPF_BIT  = 3;
   localparam int TSD_BIT  = 4;

   // Clear register fields
   localparam int CLR_A_LSB   = 0;  // coil A overload clears [3:0]
   localparam int CLR_B_LSB   = 4;  // coil B overload clears [7:4]
   localparam int CLR_OPA_BIT = 8;
   localparam int CLR_OPB_BIT = 9;

   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Current range boundaries
   localparam logic [4:0] RANGE1_FIRST = 5'h09;
   localparam logic [4:0] RANGE2_FIRST = 5'h10;
   localparam logic [4:0] RANGE3_FIRST = 5'h17;

   // Coarsest legal resolution code
   localparam logic [2:0] RES_MAX = 3'h4;

   // Open-coil time
   localparam int CLK_HZ    = 10_000_000;
   localparam int OPEN_MS   = 200;
   localparam int OPEN_CYC  = CLK_HZ / 1000 * OPEN_MS;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Analog sense inputs grouped
   typedef struct packed {
      logic       temp_warn;
      logic       temp_shut;
      logic [3:0] ovc_a;
      logic [3:0] ovc_b;
      logic       full_duty_a;
      logic       full_duty_b;
      logic       pump_low;
   } sense_t;

   // Drive outputs grouped
   typedef struct packed {
      logic [6:0] position;
      logic [4:0] amplitude;
      logic [1:0] range;
      logic       drive_a_en;
      logic       drive_b_en;
   } drive_t;

endpackage

// ==== core/microstep_translator_diagnostics.sv ====
// Step translator, peak-current, back-EMF mode and fault latches.
// Assumes sense inputs and step pulses synchronous to aclk; AXI4-Lite master.
//
// Notes on behaviour
// - New resolution takes effect only at the first step pulse after write.
// - Finer resolution: snap position to the nearest point of the new grid.
// - Coarser at a shared index: continue with zero offset.
// - Coarser at unshared index: step by new increment keeping the offset.
// - Five-bit amplitude code selects one of 32 full-scale levels.
// - Changed amplitude code applies at the next PWM period.
// - Codes group into four low-side impedance ranges 0-8,9-15,16-22,23-31.
// - Back-EMF sampled at a PWM sample/hold strobe during a coil current zero crossing.
// - Transparent mode follows coil voltage; else shows the held sample.
// - A bit selects divide by two or by four of sampled voltage.
// - Thermal warning flag set while temperature exceeds warning level.
// - Shutdown temperature sets the shutdown flag and disables all drivers.
// - Shutdown flag clears only by a read while below warning level.
// - Any over-current sets its flag and switches drivers off.
// - One over-current flag per driver transistor, in two status registers.
// - Over-current flags latch, drivers off, until controller clears them.
// - Full duty longer than 200 ms disables that coil, sets open flag.
// - Pump fault flag is 1 while the pump voltage is insufficient.
// - Fault output low while any fault flag is set.
// - Polarity bit picks rising or falling step edge; direction up/down.
// - Readable 7-bit position in finest units updates right after a step.
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module microstep_translator_diagnostics #(
   parameter int OPEN_CYCLES = step_diag_pkg::OPEN_CYC
) (
   // Clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // AXI4-Lite write
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // Motor side
   input  wire logic                 step_pulse_input,
   input  wire logic                 pwm_sample_hold_strobe,
   input  wire logic                 coil_zero_cross,
   input  wire logic [7:0]           coil_voltage,
   input  wire step_diag_pkg::sense_t sense,
   output step_diag_pkg::drive_t     drive,
   output logic                      reverse,
   output logic [7:0]                backemf_output_pin,
   output logic                      fault_output_n
);
   // Counter needs at least two states to tell start from expiry
   if (OPEN_CYCLES < 2) begin : g_open_cycles_check
      $error("OPEN_CYCLES too small");
   end

   localparam int OW = $clog2(OPEN_CYCLES + 1);

   // Step increment in finest units for a resolution code
   function automatic logic [6:0] incr(input logic [2:0] r);
      return 7'h01 << r;
   endfunction

   // ---------------- Register storage ----------------
   logic [31:0] ctrl_reg;
   logic [2:0]  res_active_reg;
   logic [6:0]  pos_reg;
   logic        step_d_reg;
   logic        tw_reg, tsd_reg, opa_reg, opb_reg, cpf_reg;
   logic [3:0]  ova_reg, ovb_reg;
   logic [OW-1:0] cnt_a_reg, cnt_b_reg;
   logic [4:0]  amp_reg;
   logic [7:0]  held_reg;

   // ---------------- AXI handshakes ----------------
   logic aw_hold_reg, w_hold_reg;
   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;

   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take  = s_axi_wvalid && s_axi_wready;
   wire [7:0]  wa  = aw_take ? s_axi_awaddr : awaddr_reg;
   wire [31:0] wd  = w_take ? s_axi_wdata : wdata_reg;
   wire [3:0]  ws  = w_take ? s_axi_wstrb : wstrb_reg;
   wire have_aw = aw_take || aw_hold_reg;
   wire have_w  = w_take || w_hold_reg;
   wire wr_fire = have_aw && have_w && !s_axi_bvalid;
   wire wr_ctrl = wr_fire && (wa == step_diag_pkg::CTRL_OFFS);
   wire wr_clr  = wr_fire && (wa == step_diag_pkg::CLEAR_OFFS);
   wire wr_ok   = wa == step_diag_pkg::CTRL_OFFS ||
                  wa == step_diag_pkg::CLEAR_OFFS;
   wire bvalid_next = wr_fire || (s_axi_bvalid && !s_axi_bready);

   wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
   wire [31:0] ctrl_next = (ctrl_reg & ~wmask) | (wd & wmask);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         awaddr_reg  <= 8'h00;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= step_diag_pkg::RESP_OKAY;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end else begin
         if (aw_take) awaddr_reg <= s_axi_awaddr;
         if (w_take) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         aw_hold_reg <= have_aw && !wr_fire;
         w_hold_reg  <= have_w && !wr_fire;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? step_diag_pkg::RESP_OKAY
                                  : step_diag_pkg::RESP_SLVERR;
         end else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         // Readies from flops: free once nothing is held and no answer waits
         s_axi_awready <= !(have_aw && !wr_fire) && !bvalid_next;
         s_axi_wready  <= !(have_w && !wr_fire) && !bvalid_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         ctrl_reg <= step_diag_pkg::CTRL_RESET;
      else if (wr_ctrl)
         ctrl_reg <= ctrl_next;
   end

   // ---------------- Read channel ----------------
   wire rd_take = s_axi_arvalid && s_axi_arready;
   wire [31:0] stat0 = {27'h0, tsd_reg, cpf_reg, opb_reg, opa_reg, tw_reg};
   logic [31:0] rd_val;
   logic        rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         step_diag_pkg::CTRL_OFFS:  rd_val = ctrl_reg;
         step_diag_pkg::STAT0_OFFS: rd_val = stat0;
         step_diag_pkg::STAT1_OFFS: rd_val = {28'h0, ova_reg};
         step_diag_pkg::STAT2_OFFS: rd_val = {28'h0, ovb_reg};
         step_diag_pkg::POS_OFFS:   rd_val = {25'h0, pos_reg};
         default: begin
            rd_val = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp   <= step_diag_pkg::RESP_OKAY;
         s_axi_arready <= 1'b1;
      end else begin
         // Ready again only once the pending answer is gone
         s_axi_arready <= !(rd_take || (s_axi_rvalid && !s_axi_rready));
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_hit ? step_diag_pkg::RESP_OKAY
                                   : step_diag_pkg::RESP_SLVERR;
         end else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- Translator ----------------
   wire [2:0] res_req = ctrl_reg[step_diag_pkg::RES_LSB +: 3];
   wire       pol     = ctrl_reg[step_diag_pkg::POL_BIT];
   wire       dir     = ctrl_reg[step_diag_pkg::DIR_BIT];
   // Codes above half step fall back to half step
   wire [2:0] res_new = (res_req > step_diag_pkg::RES_MAX)
                        ? step_diag_pkg::RES_MAX : res_req;
   wire step_edge = pol ? (!step_pulse_input && step_d_reg)
                        : (step_pulse_input && !step_d_reg);
   wire [6:0] inc_new = incr(res_new);
   wire       finer   = res_new < res_active_reg;
   // Nearest point of the finer grid: round half up
   wire [6:0] half    = inc_new >> 1;
   wire [6:0] snapped = (7'(pos_reg + half)) & ~(7'(inc_new - 7'h01));
   // Coarser keeps any offset: plain add from the current index
   wire [6:0] base    = finer ? snapped : pos_reg;
   wire [6:0] pos_next = dir ? 7'(base - inc_new) : 7'(base + inc_new);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         step_d_reg     <= 1'b0;
         pos_reg        <= 7'h00;
         res_active_reg <= 3'h0;
      end else begin
         step_d_reg <= step_pulse_input;
         if (step_edge) begin
            res_active_reg <= res_new;
            pos_reg        <= pos_next;
         end
      end
   end

   // ---------------- Amplitude ----------------
   wire [4:0] code = ctrl_reg[step_diag_pkg::CODE_LSB +: 5];
   always_ff @(posedge aclk) begin
      if (!aresetn)
         amp_reg <= 5'h00;
      else if (pwm_sample_hold_strobe)
         amp_reg <= code;
   end
   wire [1:0] range = (amp_reg >= step_diag_pkg::RANGE3_FIRST) ? 2'h3 :
                      (amp_reg >= step_diag_pkg::RANGE2_FIRST) ? 2'h2 :
                      (amp_reg >= step_diag_pkg::RANGE1_FIRST) ? 2'h1 :
                      2'h0;

   // ---------------- Back-EMF ----------------
   wire transp  = ctrl_reg[step_diag_pkg::TRANSP_BIT];
   wire div4    = ctrl_reg[step_diag_pkg::DIV_BIT];
   wire [7:0] scaled = div4 ? (coil_voltage >> 2) : (coil_voltage >> 1);
   wire sample_now = coil_zero_cross && pwm_sample_hold_strobe;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         held_reg <= 8'h00;
         backemf_output_pin <= 8'h00;
      end else begin
         if (sample_now)
            held_reg <= scaled;
         backemf_output_pin <= transp ? scaled
                               : (sample_now ? scaled : held_reg);
      end
   end

   // ---------------- Fault flags ----------------
   wire       clr_ova    = wr_clr && ws[0];
   wire [3:0] clr_a_bits = wd[step_diag_pkg::CLR_A_LSB +: 4];
   wire [3:0] clr_b_bits = wd[step_diag_pkg::CLR_B_LSB +: 4];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tw_reg  <= 1'b0;
         tsd_reg <= 1'b0;
         cpf_reg <= 1'b1;
         ova_reg <= 4'h0;
         ovb_reg <= 4'h0;
      end else begin
         tw_reg  <= sense.temp_warn;
         cpf_reg <= sense.pump_low;
         if (sense.temp_shut)
            tsd_reg <= 1'b1;
         else if (rd_take && !sense.temp_warn)
            tsd_reg <= 1'b0;
         // Set wins over a clear in the same cycle
         ova_reg <= (clr_ova ? ova_reg & ~clr_a_bits : ova_reg)
                    | sense.ovc_a;
         ovb_reg <= (clr_ova ? ovb_reg & ~clr_b_bits : ovb_reg)
                    | sense.ovc_b;
      end
   end

   // Full duty watchdog per coil
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_a_reg <= '0;
         cnt_b_reg <= '0;
         opa_reg   <= 1'b0;
         opb_reg   <= 1'b0;
      end else begin
         cnt_a_reg <= !sense.full_duty_a ? '0 :
            (cnt_a_reg == OW'(OPEN_CYCLES) ? cnt_a_reg : OW'(cnt_a_reg + 1'b1));
         cnt_b_reg <= !sense.full_duty_b ? '0 :
            (cnt_b_reg == OW'(OPEN_CYCLES) ? cnt_b_reg : OW'(cnt_b_reg + 1'b1));
         if (cnt_a_reg == OW'(OPEN_CYCLES))
            opa_reg <= 1'b1;
         else if (wr_clr && wd[step_diag_pkg::CLR_OPA_BIT])
            opa_reg <= 1'b0;
         if (cnt_b_reg == OW'(OPEN_CYCLES))
            opb_reg <= 1'b1;
         else if (wr_clr && wd[step_diag_pkg::CLR_OPB_BIT])
            opb_reg <= 1'b0;
      end
   end

   // ---------------- Outputs ----------------
   wire global_off = tsd_reg || (|ova_reg) || (|ovb_reg);
   wire any_fault = tw_reg || tsd_reg || (|ova_reg) || (|ovb_reg) ||
                    opa_reg || opb_reg || cpf_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drive          <= '0;
         reverse        <= 1'b0;
         fault_output_n <= 1'b1;
      end else begin
         drive.position   <= pos_reg;
         drive.amplitude  <= amp_reg;
         drive.range      <= range;
         drive.drive_a_en <= !global_off && !opa_reg;
         drive.drive_b_en <= !global_off && !opb_reg;
         reverse          <= dir;
         fault_output_n   <= !any_fault;
      end
   end

   // ---------------- Assertions ----------------
   AST_FAULT_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
      any_fault |=> !fault_output_n)
      else $error("fault output not low");
   AST_FAULT_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
      !any_fault |=> fault_output_n)
      else $error("fault output stuck low");
   AST_TSD_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
      sense.temp_shut |=> ##1 !drive.drive_a_en && !drive.drive_b_en)
      else $error("drivers on in shutdown");
   AST_TSD_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      tsd_reg && !rd_take |=> tsd_reg)
      else $error("shutdown flag cleared without read");
   AST_OVC_LATCH: assert property (@(posedge aclk) disable iff (!aresetn)
      (sense.ovc_a != 4'h0) |=> (ova_reg != 4'h0) ##1 !drive.drive_a_en)
      else $error("overload not latched");
   AST_STEP_POS: assert property (@(posedge aclk) disable iff (!aresetn)
      step_edge |=> pos_reg != $past(pos_reg))
      else $error("position not updated");
   AST_RES_WAIT: assert property (@(posedge aclk) disable iff (!aresetn)
      !step_edge |=> $stable(res_active_reg))
      else $error("resolution changed without step");
   AST_AMP_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn)
      !pwm_sample_hold_strobe |=> $stable(amp_reg))
      else $error("amplitude changed mid period");
   AST_OPEN_SET: assert property (@(posedge aclk) disable iff (!aresetn)
      cnt_a_reg == OW'(OPEN_CYCLES) |=> opa_reg)
      else $error("open coil not flagged");
   AST_PUMP: assert property (@(posedge aclk) disable iff (!aresetn)
      sense.pump_low |=> cpf_reg ##1 !fault_output_n)
      else $error("pump fault not shown");

endmodule // microstep_translator_diagnostics

// ==== tb/step_master_model.sv ====
// Controller-side step pulse source for the translator block.
// Assumes the bench calls its tasks; edges launched just after aclk rises.
`timescale 1ns/1ps
module step_master_model (
   // Clock
   input  wire logic aclk,
   // Step line towards the block
   output logic      step_line
);
   initial step_line = 1'b0;

   // Four cycles per level keeps every edge visible to the sampler
   task automatic edge_to(input logic v);
      @(posedge aclk);
      step_line <= v;
      repeat (3) @(posedge aclk);
   endtask

   task automatic pulse(input int n);
      repeat (n) begin
         edge_to(1'b1);
         edge_to(1'b0);
      end
   endtask
endmodule // step_master_model

// ==== tb/test_microstep_translator_diagnostics.sv ====
// Self-checking bench for the translator and diagnostics block.
// Assumes AXI4-Lite register map and sense levels as in the package.
`timescale 1ns/1ps
module test_microstep_translator_diagnostics;
   logic                  aclk, aresetn;
   logic [7:0]            awaddr, araddr, coil_voltage, bemf;
   logic                  awvalid, wvalid, bready, arvalid, rready;
   logic                  awready, wready, bvalid, arready, rvalid;
   logic [31:0]           wdata, rdata, dv;
   logic [1:0]            bresp, rresp, rs;
   logic [3:0]            wstrb;
   logic                  strobe, zc, rev, fault_n, step;
   step_diag_pkg::sense_t sense;
   step_diag_pkg::drive_t drive;
   int                    fail_count, n_checks;
   logic [4:0]            codes [7] = '{5'h08, 5'h09, 5'h0f, 5'h10,
                                        5'h16, 5'h17, 5'h1f};
   logic [1:0]            rngs  [7] = '{2'h0, 2'h1, 2'h1, 2'h2,
                                        2'h2, 2'h3, 2'h3};

   microstep_translator_diagnostics #(.OPEN_CYCLES(20)) dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .step_pulse_input(step), .pwm_sample_hold_strobe(strobe),
      .coil_zero_cross(zc), .coil_voltage(coil_voltage), .sense(sense),
      .drive(drive), .reverse(rev), .backemf_output_pin(bemf),
      .fault_output_n(fault_n));

   step_master_model host (.aclk(aclk), .step_line(step));

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      dv = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   task automatic rc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
      rd(a);
      chk(nm, e, dv);
      chk({nm, "_resp"}, {30'h0, step_diag_pkg::RESP_OKAY}, {30'h0, rs});
   endtask

   task automatic strobe_pwm();
      @(posedge aclk) strobe <= 1'b1;
      @(posedge aclk) strobe <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask

   task automatic pos(input logic [6:0] e);
      repeat (2) @(posedge aclk);
      chk("position", {25'h0, e}, {25'h0, drive.position});
   endtask

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      tally_and_finish();
   end

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, strobe, zc, coil_voltage} = '0;
      wstrb = 4'hf;
      sense = '0;
      sense.pump_low = 1'b1;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("fault_pump", 32'h0, {31'h0, fault_n});
      rc("stat0_pump", 8'h04, 32'h8);
      rc("ctrl_reset", 8'h00, step_diag_pkg::CTRL_RESET);
      sense.pump_low <= 1'b0;
      repeat (3) @(posedge aclk);
      chk("fault_clear", 32'h1, {31'h0, fault_n});
      chk("drive_on", 32'h3, {30'h0, drive.drive_a_en, drive.drive_b_en});
      // Resolution changes wait for a step
      wr(8'h00, 32'h4);
      pos(7'd0);
      host.pulse(1);
      pos(7'd16);
      wr(8'h00, 32'h0);
      host.pulse(3);
      pos(7'd19);
      // Deliberately coarsen off the shared grid
      wr(8'h00, 32'h4);
      host.pulse(1);
      pos(7'd35);
      rc("pos_reg", 8'h10, 32'd35);
      wr(8'h00, 32'h1000);
      host.pulse(1);
      pos(7'd34);
      chk("reverse", 32'h1, {31'h0, rev});
      wr(8'h00, 32'h2000);
      host.edge_to(1'b1);
      pos(7'd34);
      host.edge_to(1'b0);
      pos(7'd35);
      wr(8'h00, 32'h0);
      // Amplitude waits for the PWM period
      wr(8'h00, 32'h80);
      repeat (3) @(posedge aclk);
      chk("amp_wait", 32'h0, {27'h0, drive.amplitude});
      for (int i = 0; i < 7; i++) begin
         wr(8'h00, {23'h0, codes[i], 4'h0});
         strobe_pwm();
         chk("amp", {27'h0, codes[i]}, {27'h0, drive.amplitude});
         chk("range", {30'h0, rngs[i]}, {30'h0, drive.range});
      end
      coil_voltage <= 8'hc8;
      wr(8'h00, 32'h4000);
      repeat (3) @(posedge aclk);
      chk("bemf_div2", 32'h64, {24'h0, bemf});
      // Only byte 1 strobed: the other control bytes must survive
      wstrb <= 4'h2;
      wr(8'h00, 32'hffff_c0ff);
      wstrb <= 4'hf;
      rc("ctrl_strb", 8'h00, 32'h0000_c000);
      chk("bemf_div4", 32'h32, {24'h0, bemf});
      wr(8'h00, 32'h0);
      zc <= 1'b1;
      strobe_pwm();
      zc <= 1'b0;
      coil_voltage <= 8'h40;
      repeat (3) @(posedge aclk);
      chk("bemf_held", 32'h64, {24'h0, bemf});
      // Thermal
      sense.temp_warn <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("fault_warn", 32'h0, {31'h0, fault_n});
      rc("stat0_warn", 8'h04, 32'h1);
      sense.temp_shut <= 1'b1;
      repeat (3) @(posedge aclk);
      sense.temp_shut <= 1'b0;
      chk("drv_shut", 32'h0, {30'h0, drive.drive_a_en, drive.drive_b_en});
      rc("stat0_tsd", 8'h04, 32'h11);
      rc("stat0_hot", 8'h04, 32'h11);
      sense.temp_warn <= 1'b0;
      repeat (3) @(posedge aclk);
      rd(8'h10);
      rc("stat0_cool", 8'h04, 32'h0);
      chk("fault_cool", 32'h1, {31'h0, fault_n});
      // Short pulse, then status read once it is gone
      sense.ovc_a <= 4'h2;
      sense.ovc_b <= 4'h8;
      @(posedge aclk);
      sense.ovc_a <= 4'h0;
      sense.ovc_b <= 4'h0;
      repeat (3) @(posedge aclk);
      chk("drv_ovc", 32'h0, {30'h0, drive.drive_a_en, drive.drive_b_en});
      host.pulse(1);
      pos(7'd36);
      rc("ovc_a", 8'h08, 32'h2);
      rc("ovc_b", 8'h0c, 32'h8);
      chk("fault_ovc", 32'h0, {31'h0, fault_n});
      wr(8'h14, 32'hff);
      chk("clr_resp", {30'h0, step_diag_pkg::RESP_OKAY}, {30'h0, rs});
      rc("ovc_a_clr", 8'h08, 32'h0);
      chk("drv_back", 32'h3, {30'h0, drive.drive_a_en, drive.drive_b_en});
      // Open coil on A only
      sense.full_duty_a <= 1'b1;
      repeat (24) @(posedge aclk);
      sense.full_duty_a <= 1'b0;
      rc("stat0_open", 8'h04, 32'h2);
      chk("drv_open", 32'h1, {30'h0, drive.drive_a_en, drive.drive_b_en});
      wr(8'h14, 32'h100);
      rc("stat0_oclr", 8'h04, 32'h0);
      // Open coil on B only
      sense.full_duty_b <= 1'b1;
      repeat (24) @(posedge aclk);
      sense.full_duty_b <= 1'b0;
      rc("stat0_openb", 8'h04, 32'h4);
      chk("drv_ob", 32'h2, {30'h0, drive.drive_a_en, drive.drive_b_en});
      wr(8'h14, 32'h200);
      rc("stat0_bclr", 8'h04, 32'h0);
      wr(8'h18, 32'hffff_ffff);
      chk("wr_unmapped", {30'h0, step_diag_pkg::RESP_SLVERR}, {30'h0, rs});
      chk("fault_end", 32'h1, {31'h0, fault_n});
      rd(8'h18);
      chk("unmapped", {30'h0, step_diag_pkg::RESP_SLVERR}, {30'h0, rs});
      // Finer resolution from an off-grid point; code 7 acts as half step
      host.pulse(1);
      wr(8'h00, 32'h7);
      host.pulse(1);
      pos(7'd53);
      wr(8'h00, 32'h2);
      host.pulse(1);
      repeat (2) @(posedge aclk);
      chk("fine_grid", 32'h0, {30'h0, drive.position[1:0]});
      tally_and_finish();
   end
endmodule // test_microstep_translator_diagnostics
